/* rtl/slmp_top.v */
// status led, interrupt and two-wire management slave of the loopback module
// Notes on behaviour
// - no flag set: solid green in low power, solid red in high power
// - any flag set: blink green in low power, blink red in high power
// - low power when byte 200 bits 7:4 are zero or request pin high
// - slave works for any bus clock up to 400 kHz after init completes
// - clock line is never held low for 100 us or longer
// - reading management byte 0 returns the module type identifier
// - each transmit lane returns on the receive lane of the same index
// - request pin high forces low power, low applies programmed setting
// - interrupt output low while any latched flag set, high once all read
// - no response or acknowledge while module select input is high
`timescale 1ns/1ps
`include "slmp_defines.vh"
module slmp_top #(
  parameter [7:0] IDENT_CODE = 8'h5a, // arbitrary value
  parameter [3:0] MAX_POWER_ID = 4'h2,
  parameter BLINK_HALF_CYCLES = `SLMP_BLINK_HALF_CYC
) (
  input wire clk,
  input wire srst,
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe,
  input wire moduleSelectN,
  input wire lowPowerRequestPin,
  input wire [7:0] txLane,
  output wire [7:0] rxLane,
  input wire [7:0] flagEventTemp,
  input wire [7:0] flagEventVrt,
  input wire [7:0] flagEventVcc,
  output reg interruptOutN,
  output wire modulePresentN,
  output reg ledGreen,
  output reg ledRed,
  output reg lowPowerMode
);
  // ****************************************
  // pins and synchronisers
  // ****************************************
  // the init count does not fit in a byte, so the counter is nine bits wide
  localparam integer INIT_CYC_FULL = `SLMP_INIT_CYC;
  localparam [8:0] INIT_CYC = INIT_CYC_FULL[8:0];
  wire [3:0] pinSync;
  wire scl;
  wire sda;
  wire selN;
  wire lpPin;
  reg scl_reg;
  reg sda_reg;

  slmp_sync #(.W(4), .INIT(4'b1110)) uSync (
    .clk(clk),
    .srst(srst),
    .d({sclIn, sdaIn, moduleSelectN, lowPowerRequestPin}),
    .q(pinSync)
  );
  assign scl = pinSync[3];
  assign sda = pinSync[2];
  assign selN = pinSync[1];
  assign lpPin = pinSync[0];

  // the slave never stretches, so the clock line is only ever released
  assign sclOut = 1'b0;
  assign sclOe = 1'b0;
  assign sdaOut = 1'b0;
  assign modulePresentN = 1'b0;
  // passive copper: lanes are wired straight through, no logic in the path
  assign rxLane = txLane;

  wire sclRise = scl & ~scl_reg;
  wire sclFall = ~scl & scl_reg;
  wire startCond = scl & scl_reg & sda_reg & ~sda;
  wire stopCond = scl & scl_reg & ~sda_reg & sda;

  // ****************************************
  // management init
  // ****************************************
  reg [8:0] initCnt_reg;
  reg initDone_reg;
  always @(posedge clk) begin
    if (srst) begin
      initCnt_reg <= 9'h000;
      initDone_reg <= 1'b0;
    end else if (!initDone_reg) begin
      initCnt_reg <= initCnt_reg + 9'h001;
      if (initCnt_reg == INIT_CYC - 9'h001) initDone_reg <= 1'b1;
    end
  end

  // ****************************************
  // byte map
  // ****************************************
  reg [2:0] powerClass_reg;
  reg [7:0] flagTemp_reg;
  reg [7:0] flagVrt_reg;
  reg [7:0] flagVcc_reg;
  reg [7:0] ptr_reg;
  reg [7:0] rdData;
  wire [7:0] powerByte = {powerClass_reg, 1'b0, MAX_POWER_ID};

  always @* begin
    case (ptr_reg)
      `SLMP_OFS_IDENT: rdData = IDENT_CODE;
      `SLMP_OFS_FLAG_TEMP: rdData = flagTemp_reg;
      `SLMP_OFS_FLAG_VRT: rdData = flagVrt_reg;
      `SLMP_OFS_FLAG_VCC: rdData = flagVcc_reg;
      `SLMP_OFS_POWER: rdData = powerByte;
      default: rdData = 8'h00;
    endcase
  end

  // ****************************************
  // two-wire slave
  // ****************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ACKA = 3'd2;
  localparam [2:0] ST_WRB = 3'd3;
  localparam [2:0] ST_ACKW = 3'd4;
  localparam [2:0] ST_RDB = 3'd5;
  localparam [2:0] ST_ACKR = 3'd6;
  localparam [2:0] ST_RDLD = 3'd7;

  reg [2:0] state_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg rw_reg;
  reg firstByte_reg;
  reg rdClear;
  reg wrPower;

  always @(posedge clk) begin
    if (srst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      firstByte_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sdaOe <= 1'b0;
      rdClear <= 1'b0;
      wrPower <= 1'b0;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      rdClear <= 1'b0;
      wrPower <= 1'b0;
      if (selN || !initDone_reg) begin
        // deselected or still initialising: stay silent on the bus
        state_reg <= ST_IDLE;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state_reg <= ST_IDLE;
        sdaOe <= 1'b0;
      end else if (startCond) begin
        state_reg <= ST_ADDR;
        bitCnt_reg <= 4'h0;
        sdaOe <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_WRB: begin
            if (sclRise && bitCnt_reg != 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              bitCnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `SLMP_DEV_ADDR) begin
                  sdaOe <= 1'b1;
                  rw_reg <= shift_reg[0];
                  firstByte_reg <= 1'b1;
                  state_reg <= ST_ACKA;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                sdaOe <= 1'b1;
                state_reg <= ST_ACKW;
                firstByte_reg <= 1'b0;
                if (firstByte_reg) begin
                  ptr_reg <= shift_reg;
                end else begin
                  wrPower <= (ptr_reg == `SLMP_OFS_POWER);
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          ST_ACKA: begin
            if (sclFall) begin
              bitCnt_reg <= 4'h0;
              if (rw_reg) begin
                shift_reg <= rdData;
                sdaOe <= ~rdData[7];
                rdClear <= 1'b1;
                state_reg <= ST_RDB;
              end else begin
                sdaOe <= 1'b0;
                state_reg <= ST_WRB;
              end
            end
          end
          ST_ACKW: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state_reg <= ST_WRB;
            end
          end
          ST_RDB: begin
            if (sclFall) begin
              if (bitCnt_reg == 4'h7) begin
                sdaOe <= 1'b0;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_ACKR;
              end else begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                sdaOe <= ~shift_reg[6];
              end
            end
          end
          ST_ACKR: begin
            if (sclRise) state_reg <= sda ? ST_IDLE : ST_RDLD;
          end
          ST_RDLD: begin
            if (sclFall) begin
              bitCnt_reg <= 4'h0;
              shift_reg <= rdData;
              sdaOe <= ~rdData[7];
              rdClear <= 1'b1;
              state_reg <= ST_RDB;
            end
          end
          default: begin
            sdaOe <= 1'b0;
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // power setting and latched flags
  // ****************************************
  // a flag is cleared by the read that returned it; a new event in the
  // same cycle survives; temp and vcc latch only event bits 3:0, vrt all eight
  wire clrTemp = rdClear && ptr_reg == `SLMP_OFS_FLAG_TEMP;
  wire clrVrt = rdClear && ptr_reg == `SLMP_OFS_FLAG_VRT;
  wire clrVcc = rdClear && ptr_reg == `SLMP_OFS_FLAG_VCC;

  always @(posedge clk) begin
    if (srst) begin
      powerClass_reg <= `SLMP_POWER_RESET;
      flagTemp_reg <= 8'h00;
      flagVrt_reg <= 8'h00;
      flagVcc_reg <= 8'h00;
    end else begin
      if (wrPower)
        powerClass_reg <= shift_reg[`SLMP_POWER_CLASS_MSB:`SLMP_POWER_CLASS_LSB];
      flagTemp_reg <= (clrTemp ? 8'h00 : flagTemp_reg) | {4'h0, flagEventTemp[3:0]};
      flagVrt_reg <= (clrVrt ? 8'h00 : flagVrt_reg) | flagEventVrt;
      flagVcc_reg <= (clrVcc ? 8'h00 : flagVcc_reg) | {4'h0, flagEventVcc[3:0]};
    end
  end

  wire anyFlag = |{flagTemp_reg, flagVrt_reg, flagVcc_reg};
  // bit 4 of the power byte always reads zero, so bits 7:5 decide
  wire lowPowerNext = (powerByte[7:4] == `SLMP_POWER_LOW) || lpPin;

  // ****************************************
  // blink divider and led
  // ****************************************
  reg [26:0] blinkCnt_reg;
  reg blinkPhase_reg;
  always @(posedge clk) begin
    if (srst) begin
      blinkCnt_reg <= 27'h0;
      blinkPhase_reg <= 1'b0;
    end else if (blinkCnt_reg == BLINK_HALF_CYCLES[26:0] - 27'h1) begin
      blinkCnt_reg <= 27'h0;
      blinkPhase_reg <= ~blinkPhase_reg;
    end else begin
      blinkCnt_reg <= blinkCnt_reg + 27'h1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      lowPowerMode <= 1'b1;
      interruptOutN <= 1'b1;
      ledGreen <= 1'b0;
      ledRed <= 1'b0;
    end else begin
      lowPowerMode <= lowPowerNext;
      interruptOutN <= ~anyFlag;
      // solid when no flag, gated by blink phase when any flag is set
      ledGreen <= lowPowerNext && (!anyFlag || blinkPhase_reg);
      ledRed <= !lowPowerNext && (!anyFlag || blinkPhase_reg);
    end
  end
endmodule

/* shared/slmp_defines.vh */
// constants for the status led and management port block
`ifndef SLMP_DEFINES_VH
`define SLMP_DEFINES_VH
// ****************************************
// timing
// ****************************************
`define SLMP_CLK_PERIOD_NS 5
`define SLMP_BLINK_HALF_MS 500
`define SLMP_BLINK_HALF_CYC (`SLMP_BLINK_HALF_MS * 1000000 / `SLMP_CLK_PERIOD_NS)
`define SLMP_INIT_US 2
`define SLMP_INIT_CYC (`SLMP_INIT_US * 1000 / `SLMP_CLK_PERIOD_NS)
`define SLMP_STRETCH_MAX_US 100
// ****************************************
// two-wire slave
// ****************************************
`define SLMP_DEV_ADDR 7'h50
// ****************************************
// management byte map
// ****************************************
`define SLMP_OFS_IDENT 8'h00
`define SLMP_OFS_FLAG_TEMP 8'h09
`define SLMP_OFS_FLAG_VRT 8'h0a
`define SLMP_OFS_FLAG_VCC 8'h0b
`define SLMP_OFS_POWER 8'hc8
`define SLMP_POWER_CLASS_MSB 7
`define SLMP_POWER_CLASS_LSB 5
`define SLMP_POWER_RESET 3'h0
`define SLMP_POWER_LOW 4'h0
`endif

/* rtl/slmp_sync.v */
// two-flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module slmp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* test/slmp_top_checker.sv */
// assertions on the ports of the status led and management port block
`timescale 1ns/1ps
`include "slmp_defines.vh"
module slmp_top_checker #(
  parameter BLINK_HALF_CYCLES = 20
) (
  input wire clk,
  input wire srst,
  input wire sclIn,
  input wire sclOe,
  input wire sdaOe,
  input wire moduleSelectN,
  input wire lowPowerRequestPin,
  input wire [7:0] txLane,
  input wire [7:0] rxLane,
  input wire [7:0] flagEventVrt,
  input wire interruptOutN,
  input wire ledGreen,
  input wire ledRed,
  input wire lowPowerMode
);
  // ****************************************
  // helper counters
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reg prevGreen;
  integer runCnt;
  integer initCnt;
  // run of unchanged green while blinking; a stuck phase grows it without bound
  always @(posedge clk) begin
    prevGreen <= ledGreen;
    if (srst || ledGreen != prevGreen || interruptOutN || !lowPowerMode) runCnt <= 0;
    else runCnt <= runCnt + 1;
    if (srst) initCnt <= 0;
    else if (initCnt < `SLMP_INIT_CYC) initCnt <= initCnt + 1;
  end
  // ****************************************
  // properties
  // ****************************************
  AST_LOOPBACK: assert property (rxLane == txLane)
    else $error("receive lanes differ from transmit lanes");
  AST_NO_STRETCH: assert property (!sclOe)
    else $error("bus clock held low");
  AST_PIN_LOW_POWER: assert property (lowPowerRequestPin [*4] |-> lowPowerMode)
    else $error("request pin high but not in low power");
  AST_SOLID_GREEN: assert property ((interruptOutN && lowPowerMode) [*4] |-> ledGreen && !ledRed)
    else $error("led not solid green");
  AST_SOLID_RED: assert property ((interruptOutN && !lowPowerMode) [*4] |-> ledRed && !ledGreen)
    else $error("led not solid red");
  AST_BLINK_COLOUR: assert property ((!interruptOutN && lowPowerMode) [*3] |-> !ledRed)
    else $error("red lit while blinking green");
  AST_BLINK_PERIOD: assert property (runCnt <= BLINK_HALF_CYCLES + 2)
    else $error("blink phase did not toggle");
  AST_DESELECT: assert property (moduleSelectN [*5] |-> !sdaOe)
    else $error("data driven while deselected");
  AST_INIT_QUIET: assert property (initCnt < `SLMP_INIT_CYC |-> !sdaOe)
    else $error("data driven before init done");
  AST_DATA_CLOCK_LOW: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data changed while bus clock high");
  AST_INT_ON_EVENT: assert property ((|flagEventVrt) |-> ##[1:2] !interruptOutN)
    else $error("interrupt not asserted after event");
endmodule
bind slmp_top slmp_top_checker #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) i_slmp_top_checker (.clk(clk),
  .srst(srst), .sclIn(sclIn), .sclOe(sclOe), .sdaOe(sdaOe), .moduleSelectN(moduleSelectN),
  .lowPowerRequestPin(lowPowerRequestPin), .txLane(txLane), .rxLane(rxLane), .flagEventVrt(flagEventVrt),
  .interruptOutN(interruptOutN), .ledGreen(ledGreen), .ledRed(ledRed), .lowPowerMode(lowPowerMode));

/* test/slmp_host_model.sv */
// host controller model that bit-bangs the two-wire management bus
`timescale 1ns/1ps
module slmp_host_model (
  input wire sdaLine,
  output logic sclLow,
  output logic sdaLow
);
  // ****************************************
  // bus phases, 80 ns per bit
  // ****************************************
  // clock is released high between frames, so it stands still there
  initial begin
    sclLow = 0;
    sdaLow = 0;
  end
  task automatic startBit;
    sdaLow = 0;
    #20 sclLow = 0;
    #20 sdaLow = 1;
    #20 sclLow = 1;
    #20;
  endtask
  task automatic stopBit;
    sdaLow = 1;
    #20 sclLow = 0;
    #20 sdaLow = 0;
    #20;
  endtask
  // data only moves while the clock is low; sampled at the end of the high phase
  task automatic bitOut(input logic b, output logic s);
    sdaLow = !b;
    #20 sclLow = 0;
    #40 s = sdaLine;
    sclLow = 1;
    #20;
  endtask
  // ninth bit always released: acknowledge in on writes, not-acknowledge out on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i], s);
      q[i] = s;
    end
    bitOut(1'b1, s);
    ack = !s;
  endtask
endmodule

/* test/slmp_top_tb_top.sv */
// self-checking bench for the status led and management port block
`timescale 1ns/1ps
module slmp_top_tb_top;
  localparam [7:0] IDENT = 8'h3c; // arbitrary value
  localparam [3:0] MAXPID = 4'h2;
  logic clk = 0;
  logic srst = 1;
  logic moduleSelectN = 0;
  logic lowPowerRequestPin = 0;
  logic [7:0] txLane = 8'h00;
  logic [7:0] flagEv [0:2] = '{8'h00, 8'h00, 8'h00};
  wire sclOe, sdaOe, sclLow, sdaLow, interruptOutN, ledGreen, ledRed, lowPowerMode;
  wire [7:0] rxLane;
  wire sclLine = !(sclLow || sclOe);
  wire sdaLine = !(sdaLow || sdaOe);
  int nErrors = 0;
  int compares = 0;
  logic [7:0] q;
  logic [7:0] v;
  logic [2:0] c;
  logic a;
  logic p;
  logic blinkOn;
  logic blinkOff;
  slmp_top #(.IDENT_CODE(IDENT), .MAX_POWER_ID(MAXPID), .BLINK_HALF_CYCLES(20)) i_slmp_top (.clk(clk),
    .srst(srst), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .moduleSelectN(moduleSelectN), .lowPowerRequestPin(lowPowerRequestPin), .txLane(txLane),
    .rxLane(rxLane), .flagEventTemp(flagEv[0]), .flagEventVrt(flagEv[1]), .flagEventVcc(flagEv[2]),
    .interruptOutN(interruptOutN), .modulePresentN(), .ledGreen(ledGreen), .ledRed(ledRed),
    .lowPowerMode(lowPowerMode));
  slmp_host_model i_slmp_host_model (.sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow));
  initial forever #2.5 clk = ~clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stopTest;
    $display("errors %0d compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic regWrite(input logic [7:0] ofs, input logic [7:0] d);
    i_slmp_host_model.startBit;
    i_slmp_host_model.xfer(8'ha0, q, a);
    check("addr ack", {7'h0, a}, 8'h01);
    i_slmp_host_model.xfer(ofs, q, a);
    i_slmp_host_model.xfer(d, q, a);
    i_slmp_host_model.stopBit;
  endtask
  // pointer is set by the offset byte alone, then a repeated start turns the bus round
  task automatic regRead(input logic [7:0] ofs, output logic [7:0] r);
    i_slmp_host_model.startBit;
    i_slmp_host_model.xfer(8'ha0, q, a);
    i_slmp_host_model.xfer(ofs, q, a);
    check("ofs ack", {7'h0, a}, 8'h01);
    i_slmp_host_model.startBit;
    i_slmp_host_model.xfer(8'ha1, r, a);
    check("rd addr ack", {7'h0, a}, 8'h01);
    i_slmp_host_model.xfer(8'hff, r, a);
    i_slmp_host_model.stopBit;
  endtask
  task automatic probeAck(input string name);
    i_slmp_host_model.startBit;
    i_slmp_host_model.xfer(8'ha1, q, a);
    i_slmp_host_model.stopBit;
    check(name, {7'h0, a}, 8'h00);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(75));
    cyc(12);
    srst = 0;
    cyc(2);
    probeAck("ack during init");
    cyc(420);
    regRead(8'h00, q);
    check("ident", q, IDENT);
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 3'h0 : (i < 3) ? 3'h7 : 3'($urandom);
      p = (i < 3) ? (i == 1) : 1'($urandom);
      lowPowerRequestPin = p;
      txLane = 8'($urandom);
      regWrite(8'hc8, {c, 5'h1f});
      regRead(8'hc8, q);
      check("power byte", q, {c, 1'b0, MAXPID});
      check("rx lanes", rxLane, txLane);
      p = (c == 3'h0) || p;
      check("mode led", {5'h0, ledRed, ledGreen, lowPowerMode}, {5'h0, !p, p, p});
    end
    moduleSelectN = 1;
    cyc(5);
    probeAck("ack deselected");
    moduleSelectN = 0;
    regWrite(8'hc8, 8'he0);
    for (int k = 0; k < 3; k++) begin
      lowPowerRequestPin = (k == 1);
      v = 8'($urandom) | 8'h01;
      cyc(4);
      flagEv[k] = v;
      cyc(1);
      flagEv[k] = 8'h00;
      cyc(3);
      check("int asserted", {7'h0, interruptOutN}, 8'h00);
      blinkOn = 1'b0;
      blinkOff = 1'b0;
      for (int n = 0; n < 60; n++) begin
        cyc(1);
        if (((k == 1) ? ledGreen : ledRed) === 1'b1) blinkOn = 1'b1;
        else blinkOff = 1'b1;
      end
      check("blink toggles", {6'h0, blinkOn, blinkOff}, 8'h03);
      check("blink other colour", {7'h0, (k == 1) ? ledRed : ledGreen}, 8'h00);
      regRead(8'h09 + 8'(k), q);
      check("flag byte", q, v & ((k == 1) ? 8'hff : 8'h0f));
      for (int n = 0; n < 10 && interruptOutN !== 1'b1; n++) cyc(1);
      check("int released", {7'h0, interruptOutN}, 8'h01);
      if (interruptOutN !== 1'b1) stopTest;
    end
    stopTest;
  end
endmodule
